// ### design/bcr_pkg.sv
// Shared definitions of the branch, call and return unit: register map,
// field layouts, form codes, per-form length and state table.
// Assumes an APB master with 32-bit data and byte addresses.
package bcr_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_PC     = 8'h04;
	localparam logic [7:0] OFF_REL    = 8'h08;
	localparam logic [7:0] OFF_TARGET = 8'h0C;
	localparam logic [7:0] OFF_OPER   = 8'h10;
	localparam logic [7:0] OFF_DATA_POINTER   = 8'h14;
	localparam logic [7:0] OFF_EXTENDED_STATUS_BYTE   = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	localparam logic [7:0] OFF_SP     = 8'h20;

	// Status field positions
	localparam int STAT_BUSY    = 0;
	localparam int STAT_CARRY   = 1;
	localparam int STAT_TAKEN   = 2;
	localparam int STAT_CLEARED = 3;
	localparam int STAT_STATES  = 8;
	localparam int STAT_DEC     = 16;
	localparam int STAT_SP      = 24;

	// Reset values and the trap vector
	localparam logic [23:0] PC_RESET        = 24'hFF0000;
	localparam logic [23:0] TRAP_VECTOR_DEF = 24'hFF0040;

	// Operand classes
	localparam logic [1:0] CLASS_RAM = 2'h0;
	localparam logic [1:0] CLASS_IO  = 2'h1;
	localparam logic [1:0] CLASS_SFR = 2'h2;

	// Direct-operand penalty kinds and external-destination penalties
	localparam logic [1:0] N_NO = 2'h0;
	localparam logic [1:0] N_D1 = 2'h1;
	localparam logic [1:0] N_D2 = 2'h2;
	localparam logic [1:0] N_CL = 2'h3;
	localparam logic [1:0] X_0  = 2'h0;
	localparam logic [1:0] X_2  = 2'h1;
	localparam logic [1:0] X_3  = 2'h2;
	localparam logic [4:0] INTERRUPT_FRAME_BIT_EXTRA = 5'h05;

	// Instruction forms
	localparam logic [4:0] OP_NOP        = 5'h00;
	localparam logic [4:0] OP_BITSET_S   = 5'h01;
	localparam logic [4:0] OP_BITSET_L   = 5'h02;
	localparam logic [4:0] OP_BITCLR_S   = 5'h03;
	localparam logic [4:0] OP_BITCLR_L   = 5'h04;
	localparam logic [4:0] OP_SETCLR_S   = 5'h05;
	localparam logic [4:0] OP_SETCLR_L   = 5'h06;
	localparam logic [4:0] OP_ACCZ       = 5'h07;
	localparam logic [4:0] OP_ACCNZ      = 5'h08;
	localparam logic [4:0] OP_CMP_DIR    = 5'h09;
	localparam logic [4:0] OP_CMP_IMMA   = 5'h0A;
	localparam logic [4:0] OP_CMP_IMMR   = 5'h0B;
	localparam logic [4:0] OP_CMP_IND    = 5'h0C;
	localparam logic [4:0] OP_DEC_REG    = 5'h0D;
	localparam logic [4:0] OP_DEC_DIR    = 5'h0E;
	localparam logic [4:0] OP_ABS_GOTO   = 5'h0F;
	localparam logic [4:0] OP_EXT_GOTO   = 5'h10;
	localparam logic [4:0] OP_EXT_GOTO_I = 5'h11;
	localparam logic [4:0] OP_LNG_GOTO_I = 5'h12;
	localparam logic [4:0] OP_LNG_GOTO   = 5'h13;
	localparam logic [4:0] OP_SHORT_GOTO = 5'h14;
	localparam logic [4:0] OP_IND_GOTO   = 5'h15;
	localparam logic [4:0] OP_ABS_CALL   = 5'h16;
	localparam logic [4:0] OP_EXT_CALL_I = 5'h17;
	localparam logic [4:0] OP_EXT_CALL   = 5'h18;
	localparam logic [4:0] OP_LNG_CALL_I = 5'h19;
	localparam logic [4:0] OP_LNG_CALL   = 5'h1A;
	localparam logic [4:0] OP_RET        = 5'h1B;
	localparam logic [4:0] OP_EXTENDED_SUBROUTINE_RETURN       = 5'h1C;
	localparam logic [4:0] OP_INTERRUPT_RETURN       = 5'h1D;
	localparam logic [4:0] OP_TRAP       = 5'h1E;

	// Control word as software writes it
	typedef struct packed {
		logic        go;
		logic [18:0] rsvd;
		logic        bitVal;
		logic        intrFrame;
		logic        internalExec;
		logic        destExt;
		logic [1:0]  opClass;
		logic        srcMode;
		logic [4:0]  op;
	} bcr_ctrl_t;

	// Operand word: accumulator and the two compare operands
	typedef struct packed {
		logic [7:0] rsvd;
		logic [7:0] src2;
		logic [7:0] src1;
		logic [7:0] acc;
	} bcr_oper_t;

	// Lengths, not-taken/taken states per mode, penalty kinds, flags
	typedef struct packed {
		logic [3:0] lenBin;
		logic [3:0] lenSrc;
		logic [3:0] notBin;
		logic [3:0] takBin;
		logic [3:0] notSrc;
		logic [3:0] takSrc;
		logic [1:0] dirNote;
		logic [1:0] extAdd;
		logic       oddAdd;
		logic       intrAdd;
		logic       uncond;
	} bcr_form_t;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RUN} bcr_state_t;

	// Form table
	function automatic bcr_form_t bcrFormOf(input logic [4:0] op);
		bcr_form_t f;
		f = '0;
		case (op)
			OP_NOP:        f = {8'h11, 16'h1111, N_NO, X_0, 3'h1};
			OP_BITSET_S,
			OP_BITCLR_S:   f = {8'h33, 16'h2525, N_D1, X_0, 3'h4};
			OP_BITSET_L,
			OP_BITCLR_L:   f = {8'h54, 16'h4736, N_D1, X_0, 3'h4};
			OP_SETCLR_S:   f = {8'h33, 16'h4747, N_CL, X_0, 3'h4};
			OP_SETCLR_L:   f = {8'h54, 16'h7A69, N_CL, X_0, 3'h4};
			OP_ACCZ,
			OP_ACCNZ:      f = {8'h22, 16'h2525, N_NO, X_0, 3'h4};
			OP_CMP_DIR:    f = {8'h33, 16'h2525, N_D1, X_0, 3'h4};
			OP_CMP_IMMA:   f = {8'h33, 16'h2525, N_NO, X_0, 3'h4};
			OP_CMP_IMMR:   f = {8'h34, 16'h2536, N_NO, X_0, 3'h4};
			OP_CMP_IND:    f = {8'h34, 16'h3647, N_NO, X_0, 3'h4};
			OP_DEC_REG:    f = {8'h23, 16'h2536, N_NO, X_0, 3'h4};
			OP_DEC_DIR:    f = {8'h33, 16'h3636, N_D2, X_0, 3'h4};
			OP_ABS_GOTO:   f = {8'h22, 16'h3333, N_NO, X_2, 3'h5};
			OP_EXT_GOTO:   f = {8'h54, 16'h6655, N_NO, X_3, 3'h5};
			OP_EXT_GOTO_I: f = {8'h32, 16'h7766, N_NO, X_3, 3'h5};
			OP_LNG_GOTO_I: f = {8'h32, 16'h6655, N_NO, X_3, 3'h5};
			OP_LNG_GOTO:   f = {8'h33, 16'h5555, N_NO, X_3, 3'h5};
			OP_SHORT_GOTO: f = {8'h22, 16'h4444, N_NO, X_3, 3'h5};
			OP_IND_GOTO:   f = {8'h11, 16'h5555, N_NO, X_3, 3'h5};
			OP_ABS_CALL:   f = {8'h22, 16'h9999, N_NO, X_2, 3'h5};
			OP_EXT_CALL_I: f = {8'h32, 16'hEEDD, N_NO, X_2, 3'h5};
			OP_EXT_CALL:   f = {8'h54, 16'hEEDD, N_NO, X_2, 3'h5};
			OP_LNG_CALL_I: f = {8'h32, 16'hAA99, N_NO, X_2, 3'h5};
			OP_LNG_CALL:   f = {8'h33, 16'h9999, N_NO, X_2, 3'h5};
			OP_RET:        f = {8'h11, 16'h7777, N_NO, X_0, 3'h5};
			OP_EXTENDED_SUBROUTINE_RETURN:       f = {8'h32, 16'h9988, N_NO, X_0, 3'h5};
			OP_INTERRUPT_RETURN:       f = {8'h11, 16'h7777, N_NO, X_0, 3'h7};
			OP_TRAP:       f = {8'h21, 16'hCCBB, N_NO, X_0, 3'h3};
			default:       f = {8'h11, 16'h1111, N_NO, X_0, 3'h1};
		endcase
		return f;
	endfunction : bcrFormOf

endpackage : bcr_pkg

// ### design/bcr_branch_unit.sv
// Branch, call and return unit: executes one control-flow form per
// command, updates the program counter and a private byte stack, and
// stays busy for the documented number of states.
// Assumes an APB master; one clock cycle per core state.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module bcr_branch_unit
	import bcr_pkg::*;
#(
	parameter int          STACK_DEPTH = 64,
	parameter logic [23:0] TRAP_VECTOR = TRAP_VECTOR_DEF
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Core state
	output logic      [23:0] programCounter,
	output logic             coreBusy,
	output logic             carryFlag
);

	localparam int SPW = $clog2(STACK_DEPTH);

	bcr_state_t  stateR;
	bcr_state_t  stateNxt;
	bcr_ctrl_t   ctrlR;
	bcr_ctrl_t   wrCtrl;
	bcr_oper_t   operR;
	bcr_form_t   form;
	logic [23:0] pcR;
	logic [7:0]  relR;
	logic [23:0] targetR;
	logic [15:0] dptrR;
	logic [7:0]  psw1R;
	logic [SPW-1:0] spR;
	logic [7:0]  stk [STACK_DEPTH];
	logic        carryR;
	logic        takenR;
	logic        clearedR;
	logic [7:0]  decR;
	logic [4:0]  cntR;
	logic [4:0]  lastStatesR;
	logic        busyR;
	logic [31:0] prdataR;
	logic        preadyR;
	logic        pslverrR;
	logic        accessDone;
	logic        wrDone;
	logic        goReq;
	logic        addrOk;
	logic        idle;
	logic [3:0]  lenCur;
	logic [23:0] pcAdv;
	logic [23:0] relDest;
	logic [23:0] destPc;
	logic        taken;
	logic        carryNxt;
	logic [7:0]  decNxt;
	logic        clearNxt;
	logic [7:0]  psw1Nxt;
	logic [2:0]  pushCnt;
	logic [31:0] pushData;
	logic [2:0]  popCnt;
	logic [7:0]  top0;
	logic [7:0]  top1;
	logic [7:0]  top2;
	logic [7:0]  top3;
	logic [3:0]  stBase;
	logic [4:0]  dirAdd;
	logic [4:0]  extAdd;
	logic        oddExtra;
	logic [4:0]  statesTotal;
	logic [15:0] indSum;
	logic        cmpLess;
	logic        isCmp;

	assign idle     = (stateR == ST_IDLE);
	assign wrCtrl   = bcr_ctrl_t'(pwdata);
	assign isCmp    = (ctrlR.op >= OP_CMP_DIR) && (ctrlR.op <= OP_CMP_IND);
	assign cmpLess  = operR.src1 < operR.src2;
	assign indSum   = {8'h00, operR.acc} + dptrR;

	// Outputs straight from registers
	assign prdata         = prdataR;
	assign pready         = preadyR;
	assign pslverr        = pslverrR;
	assign programCounter = pcR;
	assign coreBusy       = busyR;
	assign carryFlag      = carryR;

	// APB handshake: no wait state, answer in the first access cycle
	assign accessDone = psel & penable & preadyR;
	assign wrDone     = accessDone & pwrite & ~pslverrR;
	assign goReq      = wrDone & (paddr == OFF_CTRL) & wrCtrl.go & idle;
	always_comb begin
		case (paddr)
			OFF_CTRL, OFF_PC, OFF_REL, OFF_TARGET, OFF_OPER,
			OFF_DATA_POINTER, OFF_EXTENDED_STATUS_BYTE, OFF_STATUS, OFF_SP: addrOk = 1'b1;
			default: addrOk = 1'b0;
		endcase
	end

	// Ready, error and read data, all captured in the setup cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			preadyR  <= 1'b0;
			pslverrR <= 1'b0;
			prdataR  <= 32'h0000_0000;
		end else begin
			preadyR <= psel & ~penable;
			if (psel & ~penable) begin
				pslverrR <= ~addrOk | (pwrite & (~idle |
					(paddr == OFF_STATUS)));
				case (paddr)
					OFF_CTRL:   prdataR <= {1'b0, ctrlR[30:0]};
					OFF_PC:     prdataR <= {8'h00, pcR};
					OFF_REL:    prdataR <= {24'h00_0000, relR};
					OFF_TARGET: prdataR <= {8'h00, targetR};
					OFF_OPER:   prdataR <= {8'h00, operR[23:0]};
					OFF_DATA_POINTER:   prdataR <= {16'h0000, dptrR};
					OFF_EXTENDED_STATUS_BYTE:   prdataR <= {24'h00_0000, psw1R};
					OFF_STATUS: begin
						prdataR <= 32'h0000_0000;
						prdataR[STAT_BUSY]    <= busyR;
						prdataR[STAT_CARRY]   <= carryR;
						prdataR[STAT_TAKEN]   <= takenR;
						prdataR[STAT_CLEARED] <= clearedR;
						prdataR[STAT_STATES +: 5] <= lastStatesR;
						prdataR[STAT_DEC +: 8]    <= decR;
						prdataR[STAT_SP +: SPW]   <= spR;
					end
					OFF_SP:     prdataR <= {{(32 - SPW){1'b0}}, spR};
					default:    prdataR <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Operand registers written by software while idle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctrlR   <= '0;
			relR    <= 8'h00;
			targetR <= 24'h00_0000;
			operR   <= '0;
			dptrR   <= 16'h0000;
		end else if (wrDone) begin
			case (paddr)
				OFF_CTRL:   ctrlR   <= wrCtrl;
				OFF_REL:    relR    <= pwdata[7:0];
				OFF_TARGET: targetR <= pwdata[23:0];
				OFF_OPER:   operR   <= {8'h00, pwdata[23:0]};
				OFF_DATA_POINTER:   dptrR   <= pwdata[15:0];
				default:    ctrlR   <= ctrlR;
			endcase
		end
	end

	// Top of stack, newest byte first
	assign top0 = stk[spR];
	assign top1 = stk[spR - SPW'(1)];
	assign top2 = stk[spR - SPW'(2)];
	assign top3 = stk[spR - SPW'(3)];

	// Effect of the pending form, evaluated in the execute cycle
	always_comb begin
		form     = bcrFormOf(ctrlR.op);
		lenCur   = ctrlR.srcMode ? form.lenSrc : form.lenBin;
		pcAdv    = pcR + {20'h0_0000, lenCur};
		relDest  = pcAdv + {{16{relR[7]}}, relR};
		destPc   = pcAdv;
		taken    = form.uncond;
		carryNxt = carryR;
		decNxt   = decR;
		clearNxt = 1'b0;
		psw1Nxt  = psw1R;
		pushCnt  = 3'h0;
		pushData = 32'h0000_0000;
		popCnt   = 3'h0;
		case (ctrlR.op)
			OP_BITSET_S, OP_BITSET_L: taken = ctrlR.bitVal;
			OP_BITCLR_S, OP_BITCLR_L: taken = ~ctrlR.bitVal;
			OP_SETCLR_S, OP_SETCLR_L: begin
				taken    = ctrlR.bitVal;
				clearNxt = ctrlR.bitVal;
			end
			OP_ACCZ:  taken = (operR.acc == 8'h00);
			OP_ACCNZ: taken = (operR.acc != 8'h00);
			OP_CMP_DIR, OP_CMP_IMMA, OP_CMP_IMMR, OP_CMP_IND: begin
				carryNxt = cmpLess;
				taken    = (operR.src1 != operR.src2);
			end
			OP_DEC_REG, OP_DEC_DIR: begin
				decNxt = operR.src1 - 8'h01;
				taken  = (decNxt != 8'h00);
			end
			OP_ABS_GOTO: destPc = {pcAdv[23:11], targetR[10:0]};
			OP_EXT_GOTO, OP_EXT_GOTO_I: destPc = targetR;
			OP_LNG_GOTO, OP_LNG_GOTO_I:
				destPc = {pcAdv[23:16], targetR[15:0]};
			OP_SHORT_GOTO: destPc = relDest;
			OP_IND_GOTO: destPc = {8'hFF, indSum};
			OP_ABS_CALL: begin
				pushCnt  = 3'h2;
				pushData = {16'h0000, pcAdv[15:0]};
				destPc   = {pcAdv[23:11], targetR[10:0]};
			end
			OP_EXT_CALL, OP_EXT_CALL_I: begin
				pushCnt  = 3'h3;
				pushData = {8'h00, pcAdv};
				destPc   = targetR;
			end
			OP_LNG_CALL, OP_LNG_CALL_I: begin
				pushCnt  = 3'h2;
				pushData = {16'h0000, pcAdv[15:0]};
				destPc   = {pcAdv[23:16], targetR[15:0]};
			end
			OP_RET: begin
				popCnt = 3'h2;
				destPc = {pcR[23:16], top0, top1};
			end
			OP_EXTENDED_SUBROUTINE_RETURN: begin
				popCnt = 3'h3;
				destPc = {top0, top1, top2};
			end
			OP_INTERRUPT_RETURN: begin
				if (ctrlR.intrFrame) begin
					popCnt  = 3'h4;
					destPc  = {top0, top1, top2};
					psw1Nxt = top3;
				end else begin
					popCnt = 3'h2;
					destPc = {pcR[23:16], top0, top1};
				end
			end
			OP_TRAP: begin
				destPc = TRAP_VECTOR;
				if (ctrlR.intrFrame) begin
					pushCnt  = 3'h4;
					pushData = {pcAdv, psw1R};
				end else begin
					pushCnt  = 3'h2;
					pushData = {16'h0000, pcAdv[15:0]};
				end
			end
			default: destPc = pcAdv;
		endcase
		if (!form.uncond && taken)
			destPc = relDest;
	end

	// State count of the pending form with all its penalties
	always_comb begin
		if (taken)
			stBase = ctrlR.srcMode ? form.takSrc : form.takBin;
		else
			stBase = ctrlR.srcMode ? form.notSrc : form.notBin;
		dirAdd = 5'h00;
		case (form.dirNote)
			N_D1: begin
				if (ctrlR.opClass == CLASS_IO)  dirAdd = 5'h01;
				if (ctrlR.opClass == CLASS_SFR) dirAdd = 5'h02;
			end
			N_D2: begin
				if (ctrlR.opClass == CLASS_IO)  dirAdd = 5'h02;
				if (ctrlR.opClass == CLASS_SFR) dirAdd = 5'h03;
			end
			N_CL: begin
				if (ctrlR.opClass == CLASS_IO)  dirAdd = 5'h03;
				if (ctrlR.opClass == CLASS_SFR) dirAdd = 5'h05;
			end
			default: dirAdd = 5'h00;
		endcase
		extAdd = 5'h00;
		if (ctrlR.destExt && taken) begin
			if (form.extAdd == X_2) extAdd = 5'h02;
			if (form.extAdd == X_3) extAdd = 5'h03;
		end
		oddExtra = form.oddAdd & taken & ctrlR.internalExec &
			~ctrlR.destExt & destPc[0];
		statesTotal = {1'b0, stBase} + dirAdd + extAdd + {4'h0, oddExtra};
		if (form.intrAdd && ctrlR.intrFrame)
			statesTotal = statesTotal + INTERRUPT_FRAME_BIT_EXTRA;
	end

	// Sequencer: one cycle per state
	always_comb begin
		case (stateR)
			ST_IDLE: stateNxt = goReq ? ST_EXEC : ST_IDLE;
			ST_EXEC: stateNxt = (statesTotal == 5'h01) ? ST_IDLE : ST_RUN;
			ST_RUN:  stateNxt = (cntR == 5'h01) ? ST_IDLE : ST_RUN;
			default: stateNxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stateR      <= ST_IDLE;
			busyR       <= 1'b0;
			cntR        <= 5'h00;
			lastStatesR <= 5'h00;
		end else begin
			stateR <= stateNxt;
			busyR  <= (stateNxt != ST_IDLE);
			if (stateR == ST_EXEC) begin
				cntR        <= statesTotal - 5'h01;
				lastStatesR <= statesTotal;
			end else if (stateR == ST_RUN) begin
				cntR <= cntR - 5'h01;
			end
		end
	end

	// Architectural results committed in the execute cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pcR      <= PC_RESET;
			carryR   <= 1'b0;
			takenR   <= 1'b0;
			clearedR <= 1'b0;
			decR     <= 8'h00;
			psw1R    <= 8'h00;
			spR      <= '0;
		end else if (stateR == ST_EXEC) begin
			pcR      <= destPc;
			carryR   <= carryNxt;
			takenR   <= taken;
			clearedR <= clearNxt;
			decR     <= decNxt;
			psw1R    <= psw1Nxt;
			spR      <= spR + SPW'(pushCnt) - SPW'(popCnt);
		end else if (wrDone) begin
			if (paddr == OFF_PC)   pcR   <= pwdata[23:0];
			if (paddr == OFF_EXTENDED_STATUS_BYTE) psw1R <= pwdata[7:0];
			if (paddr == OFF_SP)   spR   <= pwdata[SPW-1:0];
		end
	end

	// Stack writes, first byte at the lowest new slot
	always_ff @(posedge clock) begin
		if (stateR == ST_EXEC) begin
			for (int i = 0; i < 4; i++) begin
				if (3'(i) < pushCnt)
					stk[spR + SPW'(i + 1)] <= pushData[8 * i +: 8];
			end
		end
	end

	// Checks on the executed behaviour
	nop_pc_step_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		goReq && wrCtrl.op == OP_NOP |-> ##2 pcR == $past(pcR, 2) + 24'h1)
		else $error("no-operation did not step the counter by one");

	nop_one_state_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		goReq && wrCtrl.op == OP_NOP |=> busyR ##1 !busyR)
		else $error("no-operation did not last one state");

	short_goto_time_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		goReq && wrCtrl.op == OP_SHORT_GOTO && !wrCtrl.destExt &&
		!wrCtrl.internalExec |=> busyR [*4] ##1 !busyR)
		else $error("short goto did not last four states");

	ind_goto_dest_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		stateR == ST_EXEC && ctrlR.op == OP_IND_GOTO |=>
		pcR[23:16] == 8'hFF && pcR[15:0] == $past(indSum))
		else $error("indirect goto destination wrong");

	cmp_carry_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		stateR == ST_EXEC && isCmp |=> carryR == $past(cmpLess))
		else $error("compare left carry wrong");

	bit_clear_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		stateR == ST_EXEC && ctrlR.bitVal &&
		(ctrlR.op == OP_SETCLR_S || ctrlR.op == OP_SETCLR_L) |=>
		clearedR && takenR)
		else $error("test-and-clear did not clear and branch");

	ret_pop_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		stateR == ST_EXEC && ctrlR.op == OP_RET |=>
		spR == $past(spR) - SPW'(2))
		else $error("return did not pop two bytes");

	clr_port_time_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		goReq && wrCtrl.op == OP_SETCLR_S && !wrCtrl.bitVal &&
		wrCtrl.opClass == CLASS_IO |=> busyR [*7] ##1 !busyR)
		else $error("test-and-clear on a port not seven states");

	abs_ext_time_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		goReq && wrCtrl.op == OP_ABS_GOTO && wrCtrl.destExt |=>
		busyR [*5] ##1 !busyR)
		else $error("external absolute goto not five states");

	acc_zero_a: assert property (
		@(posedge clock) disable iff (!rst_b)
		stateR == ST_EXEC && ctrlR.op == OP_ACCZ && operR.acc == 8'h00 |=>
		pcR == $past(relDest))
		else $error("accumulator-zero branch missed");

endmodule : bcr_branch_unit
`default_nettype wire

// ### dv/bcr_prog_mem.sv
// Program memory model: hands out the offset byte of a relative
// branch for each instruction slot, as the fetch path would.
// Assumes a combinational fetch; slots past the table read as ones.
`timescale 1ns/100ps
`default_nettype none
module bcr_prog_mem (
	// Fetch port
	input  wire logic [3:0] slot,
	output logic      [7:0] relByte
);
	// Offset table: forward, backward and odd-landing branches
	always_comb begin
		case (slot)
			4'h0:    relByte = 8'h10;
			4'h1:    relByte = 8'hF0;
			4'h2:    relByte = 8'h05;
			default: relByte = 8'hFF;
		endcase
	end
endmodule : bcr_prog_mem
`default_nettype wire

// ### dv/test_bcr_branch_unit.sv
// Testbench of the branch, call and return unit: starts forms over
// APB and checks state counts, program counter and flags.
// Assumes the offset store model and a 25 MHz core clock.
`timescale 1ns/100ps
`default_nettype none
module test_bcr_branch_unit;
	import bcr_pkg::*;
	localparam logic [31:0] BV = 32'h800;
	localparam logic [31:0] FR = 32'h400;
	localparam logic [31:0] IX = 32'h200;
	localparam logic [31:0] DX = 32'h100;
	logic        clock, rst_b, psel, penable, pwrite;
	logic        pready, pslverr, coreBusy, carryFlag, errResp;
	logic [7:0]  paddr, relByte;
	logic [31:0] pwdata, prdata, rdData;
	logic [23:0] programCounter, relExt;
	logic [3:0]  slot;
	int          error_cnt, comparisons, busyCnt;

	bcr_branch_unit dut_u (.clock(clock), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .programCounter(programCounter),
		.coreBusy(coreBusy), .carryFlag(carryFlag));
	bcr_prog_mem mem_u (.slot(slot), .relByte(relByte));
	assign relExt = {{16{relByte[7]}}, relByte};

	// Core state clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Verdict and end of run
	task automatic test_done();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	// Compares one result
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			error_cnt++;
			test_done();
		end
		rdData = prdata;
		errResp = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Fetches an offset from program memory into the offset register
	task automatic setRel(input logic [3:0] s);
		slot = s;
		#1;
		apb(1'b1, OFF_REL, {24'h0, relByte});
	endtask : setRel

	// Starts one form from a known counter and counts its busy states
	task automatic run(input logic [23:0] pc0, input logic [4:0] op,
		input logic [31:0] fl);
		int i;
		apb(1'b1, OFF_PC, {8'h00, pc0});
		apb(1'b1, OFF_CTRL, 32'h80000000 | fl | {27'h0, op});
		busyCnt = 0;
		for (i = 0; i < 40; i++) begin
			@(posedge clock);
			if (coreBusy === 1'b1) busyCnt++;
			else if (busyCnt > 0) break;
		end
		// A form that never finishes ends the run as a failure
		if (i == 40) begin
			error_cnt++;
			test_done();
		end
	endtask : run

	// Bit jumps, test-and-clear with a port operand
	task automatic t_bits();
		setRel(4'h1);
		run(24'h001000, OP_BITSET_S, BV);
		chk(busyCnt, 5);
		chk(programCounter, 24'(24'h001003 + relExt));
		run(24'h001000, OP_BITCLR_S, BV);
		chk(programCounter, 24'h001003);
		run(24'h001000, OP_SETCLR_S, BV | 32'h40);
		chk(busyCnt, 10);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rdData[3], 1'b1);
		run(24'h001000, OP_SETCLR_S, 32'h40);
		chk(busyCnt, 7);
		chk(programCounter, 24'h001003);
	endtask : t_bits

	// Accumulator, compare and decrement branches
	task automatic t_cond();
		apb(1'b1, OFF_OPER, 32'h00201000);
		run(24'h001000, OP_ACCZ, 32'h0);
		chk(busyCnt, 5);
		run(24'h001000, OP_ACCNZ, 32'h0);
		chk(programCounter, 24'h001002);
		run(24'h001000, OP_CMP_IMMA, 32'h0);
		chk(carryFlag, 1'b1);
		run(24'h001000, OP_CMP_DIR, 32'h80);
		chk(busyCnt, 7);
		apb(1'b1, OFF_OPER, 32'h00010100);
		run(24'h001000, OP_CMP_IND, 32'h20);
		chk(busyCnt, 4);
		chk(carryFlag, 1'b0);
		run(24'h001000, OP_DEC_REG, 32'h0);
		chk(busyCnt, 2);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk(rdData[23:16], 8'h00);
	endtask : t_cond

	// Unconditional gotos and the odd internal target
	task automatic t_goto();
		run(24'h001000, OP_NOP, 32'h0);
		chk(programCounter, 24'h001001);
		chk(busyCnt, 1);
		apb(1'b1, OFF_TARGET, 32'h00123456);
		run(24'h001000, OP_ABS_GOTO, DX);
		chk(programCounter, 24'h001456);
		chk(busyCnt, 5);
		run(24'h001000, OP_EXT_GOTO, DX);
		chk(programCounter, 24'h123456);
		chk(busyCnt, 9);
		setRel(4'h2);
		run(24'h001000, OP_SHORT_GOTO, IX);
		chk(busyCnt, 5);
		chk(programCounter, 24'h001007);
		run(24'h001000, OP_SHORT_GOTO, 32'h0);
		chk(busyCnt, 4);
		apb(1'b1, OFF_DATA_POINTER, 32'h00002000);
		run(24'h001000, OP_IND_GOTO, 32'h0);
		chk(programCounter, 24'hFF2000);
	endtask : t_goto

	// Calls, returns, trap and interrupt return
	task automatic t_call();
		apb(1'b1, OFF_TARGET, 32'h00000200);
		run(24'h001000, OP_ABS_CALL, 32'h0);
		chk(busyCnt, 9);
		run(24'h001200, OP_RET, 32'h0);
		chk(programCounter, 24'h001002);
		run(24'h001000, OP_TRAP, 32'h0);
		chk(programCounter, TRAP_VECTOR_DEF);
		chk(busyCnt, 12);
		run(24'h001000, OP_INTERRUPT_RETURN, 32'h0);
		chk(programCounter, 24'h001002);
		run(24'h001000, OP_TRAP, FR);
		chk(busyCnt, 17);
		run(24'h001000, OP_INTERRUPT_RETURN, FR);
		chk(busyCnt, 12);
		run(24'h001000, OP_EXT_CALL, 32'h0);
		chk(programCounter, 24'h000200);
		chk(busyCnt, 14);
		run(24'h001000, OP_EXTENDED_SUBROUTINE_RETURN, 32'h0);
		chk(programCounter, 24'h001005);
		chk(busyCnt, 9);
		run(24'h001000, OP_LNG_CALL_I, 32'h0);
		chk(programCounter, 24'h000200);
		chk(busyCnt, 10);
		apb(1'b1, 8'h40, 32'h0);
		chk(errResp, 1'b1);
		apb(1'b1, OFF_STATUS, 32'h0);
		chk(errResp, 1'b1);
	endtask : t_call

	// Reset, then every scenario in turn
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		slot = 4'h0;
		error_cnt = 0;
		comparisons = 0;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		chk(programCounter, PC_RESET);
		t_bits();
		t_cond();
		t_goto();
		t_call();
		test_done();
	end
endmodule : test_bcr_branch_unit
`default_nettype wire
